// ### pkg/eot_pkg.sv
// Purpose : shared constants and types for the extended opcode decoder
// Assumes : instruction bytes arrive first byte in the top lane
// Notes   : cycle counts cover only the extended decode pages

package eot_pkg;

  // ----------------
  // widths
  // ----------------
  localparam int CNT_W  = 8;
  localparam int COST_W = 8;
  localparam int SUM_W  = 16;
  localparam int WAIT_W = 4;

  // ----------------
  // byte lanes and the invert bit of the instruction word
  // ----------------
  localparam int B0_MSB = 31;
  localparam int B1_MSB = 23;
  localparam int B2_MSB = 15;
  localparam int B3_MSB = 7;
  localparam int INV_BIT = 7;

  // ----------------
  // opcode values
  // ----------------
  localparam logic [7:0] OPC_PFX_01   = 8'h01;
  localparam logic [7:0] OPC_BCC_LONG = 8'h58;
  localparam logic [7:0] OPC_IMM_W    = 8'h79;
  localparam logic [7:0] OPC_IMM_L    = 8'h7A;
  localparam logic [7:0] OPC_BIT_RT   = 8'h7C;
  localparam logic [7:0] OPC_BIT_RM   = 8'h7D;
  localparam logic [7:0] OPC_BIT_AT   = 8'h7E;
  localparam logic [7:0] OPC_BIT_AM   = 8'h7F;
  localparam logic [7:0] OPC2_MUL     = 8'hC0;
  localparam logic [7:0] OPC2_DIV     = 8'hD0;
  localparam logic [7:0] OPC2_LOGL    = 8'hF0;
  localparam logic [7:0] OPC2_CTL     = 8'h40;
  localparam logic [3:0] OPC3_MULDIV  = 4'h5;
  localparam logic [3:0] OPC3_CTL     = 4'h0;
  localparam logic [3:0] OPC3_LOGL    = 4'h6;
  localparam logic [3:0] OPC3_BIT_A   = 4'h6;
  localparam logic [3:0] OPC3_BIT_B   = 4'h7;
  localparam logic [3:0] IMM_LAST     = 4'h6;

  // ----------------
  // cycle counts per instruction form
  // ----------------
  localparam logic [CNT_W-1:0] CNT_BCC_I   = 8'h02;
  localparam logic [CNT_W-1:0] CNT_BCC_N   = 8'h02;
  localparam logic [CNT_W-1:0] CNT_IMMW_I  = 8'h02;
  localparam logic [CNT_W-1:0] CNT_IMML_I  = 8'h03;
  localparam logic [CNT_W-1:0] CNT_MD_I    = 8'h02;
  localparam logic [CNT_W-1:0] CNT_MDB_N   = 8'h0C;
  localparam logic [CNT_W-1:0] CNT_MDW_N   = 8'h14;
  localparam logic [CNT_W-1:0] CNT_LOGL_I  = 8'h02;
  localparam logic [CNT_W-1:0] CNT_CTL_I   = 8'h02;
  localparam logic [CNT_W-1:0] CNT_CTL_M   = 8'h01;
  localparam logic [CNT_W-1:0] CNT_BIT_I   = 8'h02;
  localparam logic [CNT_W-1:0] CNT_BITR_L  = 8'h01;
  localparam logic [CNT_W-1:0] CNT_BITW_L  = 8'h02;

  // ----------------
  // per-cycle state costs
  // ----------------
  localparam logic [COST_W-1:0] S_MEM      = 8'h02;
  localparam logic [COST_W-1:0] S_INT      = 8'h01;
  localparam logic [COST_W-1:0] S_P8_FETCH = 8'h06;
  localparam logic [COST_W-1:0] S_P8_BYTE  = 8'h03;
  localparam logic [COST_W-1:0] S_P8_WORD  = 8'h06;
  localparam logic [COST_W-1:0] S_P16      = 8'h03;
  localparam logic [COST_W-1:0] S_E8_FETCH = 8'h04;
  localparam logic [COST_W-1:0] S_E8_BYTE  = 8'h02;
  localparam logic [COST_W-1:0] S_E8_WORD  = 8'h04;
  localparam logic [COST_W-1:0] S_E8_3BASE = 8'h06;
  localparam logic [COST_W-1:0] S_E8_3BYTE = 8'h03;
  localparam logic [COST_W-1:0] S_E16_2ST  = 8'h02;
  localparam logic [COST_W-1:0] S_E16_3ST  = 8'h03;

  // ----------------
  // types
  // ----------------
  typedef enum logic [2:0] {
    ACC_ONCHIP_MEM = 3'h0,
    ACC_PERIPH_8   = 3'h1,
    ACC_PERIPH_16  = 3'h2,
    ACC_EXT8_2ST   = 3'h3,
    ACC_EXT8_3ST   = 3'h4,
    ACC_EXT16_2ST  = 3'h5,
    ACC_EXT16_3ST  = 3'h6
  } eot_acc_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } eot_size_e;

  typedef enum logic [4:0] {
    OP_NONE          = 5'h00,
    OP_BRANCH        = 5'h01,
    OP_MOV_IMM       = 5'h02,
    OP_ADD_IMM       = 5'h03,
    OP_CMP_IMM       = 5'h04,
    OP_SUB_IMM       = 5'h05,
    OP_OR_IMM        = 5'h06,
    OP_XOR_IMM       = 5'h07,
    OP_AND_IMM       = 5'h08,
    OP_SIGNED_MUL    = 5'h09,
    OP_SIGNED_DIV    = 5'h0A,
    OP_OR_LONG       = 5'h0B,
    OP_XOR_LONG      = 5'h0C,
    OP_AND_LONG      = 5'h0D,
    OP_CTL_LOAD_STORE = 5'h0E,
    OP_BIT_TEST      = 5'h0F,
    OP_BIT_SET       = 5'h10,
    OP_BIT_CLEAR     = 5'h11,
    OP_BIT_INVERT    = 5'h12,
    OP_BIT_STORE     = 5'h13,
    OP_BIT_OR        = 5'h14,
    OP_BIT_XOR       = 5'h15,
    OP_BIT_AND       = 5'h16
  } eot_op_e;

  typedef struct packed {
    logic [CNT_W-1:0] fetch;
    logic [CNT_W-1:0] branch_rd;
    logic [CNT_W-1:0] stack;
    logic [CNT_W-1:0] byte_data;
    logic [CNT_W-1:0] word_data;
    logic [CNT_W-1:0] intern;
  } eot_cnt_s;

  typedef struct packed {
    logic [COST_W-1:0] fetch;
    logic [COST_W-1:0] branch_rd;
    logic [COST_W-1:0] stack;
    logic [COST_W-1:0] byte_data;
    logic [COST_W-1:0] word_data;
    logic [COST_W-1:0] intern;
  } eot_cost_s;

endpackage

// ### pkg/eot_cost_if.sv
// Purpose : carries access conditions to the cost table and costs back
// Assumes : purely combinational path inside one clock
// Notes   : none

`timescale 1ns/100ps

interface eot_cost_if;
  import eot_pkg::*;
  eot_acc_e          fetch_acc;
  eot_acc_e          stack_acc;
  eot_acc_e          data_acc;
  logic [WAIT_W-1:0] wait_m;
  eot_cost_s         cost;

  modport user (output fetch_acc, stack_acc, data_acc, wait_m,
                input  cost);
  modport table_side (input  fetch_acc, stack_acc, data_acc, wait_m,
                      output cost);
endinterface

// ### hw/eot_state_cost.sv
// Purpose : per-cycle state cost for each cycle class
// Assumes : wait count is already stable in the clock domain
// Notes   : purely combinational

`timescale 1ns/100ps

module eot_state_cost
  import eot_pkg::*;
(
  // cost lookup
  eot_cost_if.table_side cif
);
  import eot_pkg::*;

  // 6 + 2m must fit the cost width
  if (WAIT_W > COST_W - 3) begin : g_chk
    $error("eot_state_cost: wait width too large for cost width");
  end

  // ------------------------------------------------------------------
  // cost of one fetch-like, byte or word cycle
  // ------------------------------------------------------------------
  // kind: 0 fetch/branch/stack, 1 byte data, 2 word data
  function automatic logic [COST_W-1:0] cost_of(
    input eot_acc_e          acc,
    input logic [1:0]        kind,
    input logic [WAIT_W-1:0] m
  );
    logic [COST_W-1:0] mw;
    mw = COST_W'(m);
    case (acc)
      ACC_ONCHIP_MEM: cost_of = S_MEM; //[RL4]
      ACC_PERIPH_8: begin
        case (kind)
          2'h1:    cost_of = S_P8_BYTE; //[RL5]
          2'h2:    cost_of = S_P8_WORD; //[RL6]
          default: cost_of = S_P8_FETCH; //[RL4]
        endcase
      end
      ACC_PERIPH_16: cost_of = S_P16; //[RL4]
      ACC_EXT8_2ST: begin
        case (kind)
          2'h1:    cost_of = S_E8_BYTE; //[RL5]
          2'h2:    cost_of = S_E8_WORD; //[RL6]
          default: cost_of = S_E8_FETCH; //[RL4]
        endcase
      end
      ACC_EXT8_3ST: begin
        // m is the wait states added to each three-state external access
        if (kind == 2'h1) begin
          cost_of = S_E8_3BYTE + mw; //[RL5] [RL13]
        end else begin
          cost_of = S_E8_3BASE + (mw << 1); //[RL4] [RL6] [RL13]
        end
      end
      ACC_EXT16_2ST: cost_of = S_E16_2ST; //[RL7]
      ACC_EXT16_3ST: cost_of = S_E16_3ST + mw; //[RL7] [RL13]
      default:       cost_of = S_MEM;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // class costs
  // ------------------------------------------------------------------
  always_comb begin
    cif.cost.fetch     = cost_of(cif.fetch_acc, 2'h0, cif.wait_m); //[RL3]
    cif.cost.branch_rd = cost_of(cif.fetch_acc, 2'h0, cif.wait_m);
    cif.cost.stack     = cost_of(cif.stack_acc, 2'h0, cif.wait_m);
    cif.cost.byte_data = cost_of(cif.data_acc, 2'h1, cif.wait_m);
    cif.cost.word_data = cost_of(cif.data_acc, 2'h2, cif.wait_m);
    cif.cost.intern    = S_INT; //[RL7]
  end

endmodule

// ### hw/eot_decode.sv
// Purpose : extended opcode page decode and execution state count
// Assumes : instruction bytes come from fetch logic on clock_i
// Notes   : one result per accepted instruction, one cycle later
//
// Functional notes
// [RL1] states equal sum of six class cycle counts times class state costs
// [RL2] each decoded form gets fixed fetch, data and other cycle counts
// [RL3] state cost chosen from memory, peripheral or external access type
// [RL4] fetch, branch read, stack: 2 mem, 6/3 peripheral, 4 or 6+2m ext8
// [RL5] byte data: 3 peripheral8, 2 ext8 two-state, 3+m ext8 three-state
// [RL6] word data: 6 peripheral8, 4 ext8 two-state, 6+2m ext8 three-state
// [RL7] internal cycle 1 state; ext16 fetch 3+m three-state, 2 two-state
// [RL8] first byte 58: second high nibble picks one of sixteen branch tests
// [RL9] first byte 79/7A: nibble 0..6 picks mov,add,cmp,sub,or,xor,and
// [RL10] prefixes 01C05/01D05 decode signed multiply/divide, size by nibble
// [RL11] 7C/7D: nibble after prefix is register, sub-opcode picks bit op
// [RL12] 7E/7F: second byte is 8-bit absolute address, same bit ops
// [RL13] m is wait states inserted into each external access; the cost table adds m only to three-state external accesses
// [RL14] unassigned opcode combinations are flagged undefined

`timescale 1ns/100ps

module eot_decode
  import eot_pkg::*;
#(
  parameter int WAIT_BITS = WAIT_W
)
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              clk_en_i,
  // instruction in
  input  wire logic              instr_valid_i,
  input  wire logic [31:0]       instr_i,
  // access conditions
  input  eot_pkg::eot_acc_e      fetch_acc_i,
  input  eot_pkg::eot_acc_e      stack_acc_i,
  input  eot_pkg::eot_acc_e      data_acc_i,
  input  wire logic [WAIT_BITS-1:0] wait_states_i,
  // decode result
  output logic                   done_o,
  output logic                   undefined_o,
  output eot_pkg::eot_op_e       op_o,
  output eot_pkg::eot_size_e     size_o,
  output logic [3:0]             cond_o,
  output logic [3:0]             reg_o,
  output logic [7:0]             abs_addr_o,
  output logic                   abs_mode_o,
  output logic                   invert_o,
  // timing result
  output eot_pkg::eot_cnt_s      cnt_o,
  output logic [SUM_W-1:0]       states_o
);
  import eot_pkg::*;

  if (WAIT_BITS != WAIT_W) begin : g_chk
    $error("eot_decode: wait width must match cost table");
  end

  // ----------------
  // byte lanes
  // ----------------
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;

  assign b0 = instr_i[B0_MSB -: 8];
  assign b1 = instr_i[B1_MSB -: 8];
  assign b2 = instr_i[B2_MSB -: 8];
  assign b3 = instr_i[B3_MSB -: 8];

  // ----------------
  // cost table
  // ----------------
  eot_cost_if cif ();

  assign cif.fetch_acc = fetch_acc_i;
  assign cif.stack_acc = stack_acc_i;
  assign cif.data_acc  = data_acc_i;
  assign cif.wait_m    = wait_states_i; //[RL13]

  eot_state_cost u_cost (
    .cif (cif.table_side)
  );

  // ----------------
  // decode
  // ----------------
  eot_op_e   op_c;
  eot_size_e size_c;
  logic      undef_c;
  logic [3:0] cond_c;
  logic [3:0] reg_c;
  logic [7:0] aa_c;
  logic      abs_c;
  logic      inv_c;
  eot_cnt_s  cnt_c;

  always_comb begin
    op_c    = OP_NONE;
    size_c  = SZ_BYTE;
    undef_c = 1'b1; //[RL14]
    cond_c  = 4'h0;
    reg_c   = 4'h0;
    aa_c    = 8'h00;
    abs_c   = 1'b0;
    inv_c   = 1'b0;
    cnt_c   = '0;
    case (b0)
      OPC_BCC_LONG: begin
        // low nibble must be zero for the long branch form
        if (b1[3:0] == 4'h0) begin
          op_c         = OP_BRANCH;
          cond_c       = b1[7:4]; //[RL8]
          size_c       = SZ_WORD;
          undef_c      = 1'b0;
          cnt_c.fetch  = CNT_BCC_I; //[RL2]
          cnt_c.intern = CNT_BCC_N;
        end
      end
      OPC_IMM_W, OPC_IMM_L: begin
        if (b1[7:4] <= IMM_LAST) begin
          op_c    = eot_op_e'(5'(OP_MOV_IMM) + 5'(b1[7:4])); //[RL9]
          reg_c   = b1[3:0];
          undef_c = 1'b0;
          if (b0 == OPC_IMM_W) begin
            size_c      = SZ_WORD;
            cnt_c.fetch = CNT_IMMW_I; //[RL2]
          end else begin
            size_c      = SZ_LONG;
            cnt_c.fetch = CNT_IMML_I;
          end
        end
      end
      OPC_PFX_01: begin
        case (b1)
          OPC2_MUL, OPC2_DIV: begin
            // even size nibble multiplies, odd divides
            if (b2[7:4] == OPC3_MULDIV && b2[3:2] == 2'h0 &&
                b2[0] == (b1 == OPC2_DIV)) begin
              op_c    = (b1 == OPC2_MUL) ? OP_SIGNED_MUL
                                         : OP_SIGNED_DIV; //[RL10]
              size_c  = b2[1] ? SZ_WORD : SZ_BYTE;
              reg_c   = b3[3:0];
              undef_c = 1'b0;
              cnt_c.fetch  = CNT_MD_I; //[RL2]
              cnt_c.intern = b2[1] ? CNT_MDW_N : CNT_MDB_N;
            end
          end
          OPC2_LOGL: begin
            if (b2[7:4] == OPC3_LOGL && b2[3:0] >= 4'h4 &&
                b2[3:0] <= 4'h6) begin
              op_c    = eot_op_e'(5'(OP_OR_LONG) + 5'(b2[3:0] - 4'h4));
              size_c  = SZ_LONG;
              reg_c   = b3[3:0];
              undef_c = 1'b0;
              cnt_c.fetch = CNT_LOGL_I;
            end
          end
          OPC2_CTL: begin
            // only odd columns from 9 up carry the control transfer
            if (b2[7:4] == OPC3_CTL + 4'h6 && b2[3] && b2[0]) begin
              op_c    = OP_CTL_LOAD_STORE;
              size_c  = SZ_WORD;
              undef_c = 1'b0;
              cnt_c.fetch     = CNT_CTL_I;
              cnt_c.word_data = CNT_CTL_M;
            end
          end
          default: begin
          end
        endcase
      end
      OPC_BIT_RT, OPC_BIT_RM, OPC_BIT_AT, OPC_BIT_AM: begin
        abs_c = b0[1]; //[RL12]
        if (b0[1]) begin
          aa_c = b1; //[RL12]
        end else begin
          reg_c = b1[7:4]; //[RL11]
        end
        // register forms need a zero low nibble in the second byte
        if ((b0[1] || b1[3:0] == 4'h0) &&
            (b2[7:4] == OPC3_BIT_A || b2[7:4] == OPC3_BIT_B)) begin
          cnt_c.fetch = CNT_BIT_I; //[RL2]
          if (!b0[0]) begin
            // test and logic page
            if (b2[3:0] == 4'h3) begin
              op_c    = OP_BIT_TEST; //[RL11] [RL12]
              undef_c = 1'b0;
            end else if (b2[7:4] == OPC3_BIT_B && b2[3:0] >= 4'h4 &&
                         b2[3:0] <= 4'h6) begin
              op_c    = eot_op_e'(5'(OP_BIT_OR) + 5'(b2[3:0] - 4'h4));
              inv_c   = b3[INV_BIT];
              undef_c = 1'b0;
            end
            cnt_c.byte_data = CNT_BITR_L;
          end else begin
            // modify page: read and write back the byte
            if (b2[3:0] <= 4'h2) begin
              op_c    = eot_op_e'(5'(OP_BIT_SET) + 5'(b2[3:0] == 4'h1 ?
                                  4'h2 : (b2[3:0] == 4'h2 ? 4'h1 : 4'h0)));
              undef_c = 1'b0;
            end else if (b2[7:4] == OPC3_BIT_A && b2[3:0] == 4'h7) begin
              op_c    = OP_BIT_STORE;
              inv_c   = b3[INV_BIT];
              undef_c = 1'b0;
            end
            cnt_c.byte_data = CNT_BITW_L;
          end
        end
      end
      default: begin
      end
    endcase
    if (undef_c) begin
      op_c  = OP_NONE; //[RL14]
      cnt_c = '0;
      inv_c = 1'b0;
    end
  end

  // ----------------
  // state count
  // ----------------
  // widened before multiplying so no product overflows the sum width
  function automatic logic [SUM_W-1:0] prod(
    input logic [CNT_W-1:0]  c,
    input logic [COST_W-1:0] s
  );
    prod = SUM_W'(SUM_W'(c) * SUM_W'(s));
  endfunction

  logic [SUM_W-1:0] states_c;

  always_comb begin
    states_c = prod(cnt_c.fetch,     cif.cost.fetch)
             + prod(cnt_c.branch_rd, cif.cost.branch_rd)
             + prod(cnt_c.stack,     cif.cost.stack)
             + prod(cnt_c.byte_data, cif.cost.byte_data)
             + prod(cnt_c.word_data, cif.cost.word_data)
             + prod(cnt_c.intern,    cif.cost.intern); //[RL1]
  end

  // ----------------
  // output registers
  // ----------------
  logic             done_r,  done_nxt;
  logic             undef_r, undef_nxt;
  eot_op_e          op_r,    op_nxt;
  eot_size_e        size_r,  size_nxt;
  logic [3:0]       cond_r,  cond_nxt;
  logic [3:0]       reg_r,   reg_nxt;
  logic [7:0]       aa_r,    aa_nxt;
  logic             abs_r,   abs_nxt;
  logic             inv_r,   inv_nxt;
  eot_cnt_s         cnt_r,   cnt_nxt;
  logic [SUM_W-1:0] st_r,    st_nxt;

  always_comb begin
    done_nxt  = 1'b0;
    undef_nxt = undef_r;
    op_nxt    = op_r;
    size_nxt  = size_r;
    cond_nxt  = cond_r;
    reg_nxt   = reg_r;
    aa_nxt    = aa_r;
    abs_nxt   = abs_r;
    inv_nxt   = inv_r;
    cnt_nxt   = cnt_r;
    st_nxt    = st_r;
    // results hold until the next accepted instruction
    if (instr_valid_i) begin
      done_nxt  = 1'b1;
      undef_nxt = undef_c;
      op_nxt    = op_c;
      size_nxt  = size_c;
      cond_nxt  = cond_c;
      reg_nxt   = reg_c;
      aa_nxt    = aa_c;
      abs_nxt   = abs_c;
      inv_nxt   = inv_c;
      cnt_nxt   = cnt_c;
      st_nxt    = states_c;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      done_r  <= 1'b0;
      undef_r <= 1'b0;
      op_r    <= OP_NONE;
      size_r  <= SZ_BYTE;
      cond_r  <= 4'h0;
      reg_r   <= 4'h0;
      aa_r    <= 8'h00;
      abs_r   <= 1'b0;
      inv_r   <= 1'b0;
      cnt_r   <= '0;
      st_r    <= '0;
    end else if (clk_en_i) begin
      done_r  <= done_nxt;
      undef_r <= undef_nxt;
      op_r    <= op_nxt;
      size_r  <= size_nxt;
      cond_r  <= cond_nxt;
      reg_r   <= reg_nxt;
      aa_r    <= aa_nxt;
      abs_r   <= abs_nxt;
      inv_r   <= inv_nxt;
      cnt_r   <= cnt_nxt;
      st_r    <= st_nxt;
    end
  end

  assign done_o      = done_r;
  assign undefined_o = undef_r;
  assign op_o        = op_r;
  assign size_o      = size_r;
  assign cond_o      = cond_r;
  assign reg_o       = reg_r;
  assign abs_addr_o  = aa_r;
  assign abs_mode_o  = abs_r;
  assign invert_o    = inv_r;
  assign cnt_o       = cnt_r;
  assign states_o    = st_r;

endmodule

// ### test/eot_fetch_model.sv
// Purpose : stands in for the fetch path that hands words to the decoder
// Assumes : one word per go_i pulse, registered on clock_i
// Notes   : an idle word bus inverts itself on every clock

`timescale 1ns/100ps

module eot_fetch_model (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // request from the bench
  input  wire logic        go_i,
  input  wire logic [31:0] word_i,
  // toward the decoder
  output logic             instr_valid_o,
  output logic [31:0]      instr_o
);
  // idle bus flips so a stale word can never pass for a fresh one
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      instr_valid_o <= 1'b0;
      instr_o       <= 32'h0;
    end else begin
      instr_valid_o <= go_i;
      instr_o       <= go_i ? word_i : ~instr_o;
    end
  end
endmodule

// ### test/eot_decode_checker.sv
// Purpose : timing and decode checks on the decoder ports
// Assumes : single clock, async active-high reset
// Notes   : costs are latched at the taking edge beside the word

`timescale 1ns/100ps

module eot_decode_checker
  import eot_pkg::*;
#(
  parameter int WAIT_BITS = WAIT_W
)
(
  input wire logic          clock_i,
  input wire logic          reset_i,
  input wire logic          clk_en_i,
  input wire logic          instr_valid_i,
  input wire logic [31:0]   instr_i,
  input eot_acc_e           fetch_acc_i,
  input eot_acc_e           stack_acc_i,
  input eot_acc_e           data_acc_i,
  input wire logic [WAIT_BITS-1:0] wait_states_i,
  input wire logic          done_o,
  input wire logic          undefined_o,
  input eot_op_e            op_o,
  input eot_size_e          size_o,
  input wire logic [3:0]    cond_o,
  input wire logic [3:0]    reg_o,
  input wire logic [7:0]    abs_addr_o,
  input wire logic          abs_mode_o,
  input wire logic          invert_o,
  input eot_cnt_s           cnt_o,
  input wire logic [SUM_W-1:0] states_o
);
  logic [31:0] w_r;
  int          fc_r, sc_r, bc_r, wc_r;

  // kind 0 fetch class, 1 byte data, 2 word data
  function automatic int cst(eot_acc_e a, int k, int m);
    case (a)
      ACC_ONCHIP_MEM: return 2;
      ACC_PERIPH_8:   return (k == 1) ? 3 : 6;
      ACC_PERIPH_16:  return 3;
      ACC_EXT8_2ST:   return (k == 1) ? 2 : 4;
      ACC_EXT8_3ST:   return (k == 1) ? 3 + m : 6 + 2 * m;
      ACC_EXT16_2ST:  return 2;
      default:        return 3 + m;
    endcase
  endfunction

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      w_r <= 32'h0;
      fc_r <= 0;
      sc_r <= 0;
      bc_r <= 0;
      wc_r <= 0;
    end else if (clk_en_i) begin
      w_r  <= instr_i;
      fc_r <= cst(fetch_acc_i, 0, int'(wait_states_i));
      sc_r <= cst(stack_acc_i, 0, int'(wait_states_i));
      bc_r <= cst(data_acc_i, 1, int'(wait_states_i));
      wc_r <= cst(data_acc_i, 2, int'(wait_states_i));
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_done;
    $past(clk_en_i) |-> done_o == $past(instr_valid_i);
  endproperty
  a_done: assert property (p_done) else $error("done timing");
  property p_hold;
    !done_o |-> $stable(states_o) && $stable(op_o) && $stable(cnt_o);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_sum;
    done_o |-> int'(states_o) == int'(cnt_o.fetch) * fc_r
      + int'(cnt_o.branch_rd) * fc_r + int'(cnt_o.stack) * sc_r
      + int'(cnt_o.byte_data) * bc_r + int'(cnt_o.word_data) * wc_r
      + int'(cnt_o.intern);
  endproperty
  a_sum: assert property (p_sum) else $error("state sum");
  property p_undef;
    done_o && undefined_o |-> op_o == OP_NONE && states_o == 16'h0
      && cnt_o == '0;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined out");
  property p_branch;
    done_o && w_r[31:24] == 8'h58 && w_r[19:16] == 4'h0
      |-> op_o == OP_BRANCH && cond_o == w_r[23:20];
  endproperty
  a_branch: assert property (p_branch) else $error("branch");
  property p_imm;
    done_o && w_r[31:24] inside {8'h79, 8'h7A}
      |-> (w_r[23:20] <= 4'h6) ? (op_o == eot_op_e'(5'(OP_MOV_IMM)
      + 5'(w_r[23:20])) && !undefined_o) : undefined_o;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate");
  property p_mul;
    done_o && w_r[31:12] == 20'h01C05 && w_r[11:8] inside {4'h0, 4'h2}
      |-> op_o == OP_SIGNED_MUL;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply");
  property p_div;
    done_o && w_r[31:12] == 20'h01D05 && w_r[11:8] inside {4'h1, 4'h3}
      |-> op_o == OP_SIGNED_DIV;
  endproperty
  a_div: assert property (p_div) else $error("divide");
  property p_bitreg;
    done_o && w_r[31:24] == 8'h7C && w_r[19:16] == 4'h0
      && w_r[15:8] == 8'h63 |-> op_o == OP_BIT_TEST && reg_o == w_r[23:20];
  endproperty
  a_bitreg: assert property (p_bitreg) else $error("bit reg");
  property p_abs;
    done_o && w_r[31:24] == 8'h7E && w_r[15:8] == 8'h63
      |-> abs_mode_o && abs_addr_o == w_r[23:16] && op_o == OP_BIT_TEST;
  endproperty
  a_abs: assert property (p_abs) else $error("bit absolute");

  c_branch: cover property (done_o && op_o == OP_BRANCH);
  c_undef:  cover property (done_o && undefined_o);
  c_abs:    cover property (done_o && abs_mode_o);
endmodule

bind eot_decode eot_decode_checker #(.WAIT_BITS(WAIT_BITS)) i_chk (.*);

// ### test/tb_eot_decode.sv
// Purpose : self-checking bench for the extended opcode decoder
// Assumes : words reach the decoder through the fetch model
// Notes   : expected sums are worked by hand from the cost table

`timescale 1ns/100ps

module tb_eot_decode;
  import eot_pkg::*;
  typedef struct {
    logic [31:0] w; eot_acc_e fa; eot_acc_e da; logic [3:0] m;
    eot_op_e op; logic ud; logic [15:0] st;
  } eot_row_s;
  logic clk = 1'b0, rst = 1'b1, en = 1'b1, go = 1'b0, valid, done, ud;
  logic abs_mode, inv;
  logic [31:0] word = 32'h0, instr;
  logic [3:0] m = 4'h0, cond, rg;
  logic [7:0] abs_addr;
  logic [15:0] states;
  eot_acc_e fa = ACC_ONCHIP_MEM, da = ACC_ONCHIP_MEM;
  eot_op_e op;
  eot_size_e size;
  eot_cnt_s cnt;
  int err_count = 0, check_count = 0;
  localparam eot_acc_e MEM = ACC_ONCHIP_MEM;
  eot_row_s rows[11] = '{
    '{32'h58000000, MEM, MEM, 4'h0, OP_BRANCH, 0, 6},
    '{32'h7D006000, ACC_EXT16_3ST, ACC_PERIPH_8, 4'h1, OP_BIT_SET, 0, 14},
    '{32'h01C05000, MEM, MEM, 4'h0, OP_SIGNED_MUL, 0, 16},
    '{32'h01C05200, MEM, MEM, 4'h0, OP_SIGNED_MUL, 0, 24},
    '{32'h01D05100, MEM, MEM, 4'h0, OP_SIGNED_DIV, 0, 16},
    '{32'h01D05300, MEM, MEM, 4'h0, OP_SIGNED_DIV, 0, 24},
    '{32'h01F06500, MEM, MEM, 4'h0, OP_XOR_LONG, 0, 4},
    '{32'h01406900, MEM, MEM, 4'h0, OP_CTL_LOAD_STORE, 0, 6},
    '{32'h79700000, MEM, MEM, 4'h0, OP_NONE, 1, 0},
    '{32'h01C05100, MEM, MEM, 4'h0, OP_NONE, 1, 0},
    '{32'h58010000, MEM, MEM, 4'h0, OP_NONE, 1, 0}};
  int fexp[7] = '{6, 18, 9, 12, 30, 6, 15};
  int dexp[7] = '{6, 7, 7, 6, 9, 6, 9};

  eot_fetch_model i_eot_fetch_model (.clock_i(clk), .reset_i(rst),
    .go_i(go), .word_i(word), .instr_valid_o(valid), .instr_o(instr));
  eot_decode i_eot_decode (.clock_i(clk), .reset_i(rst), .clk_en_i(en),
    .instr_valid_i(valid), .instr_i(instr), .fetch_acc_i(fa),
    .stack_acc_i(fa), .data_acc_i(da), .wait_states_i(m), .done_o(done),
    .undefined_o(ud), .op_o(op), .size_o(size), .cond_o(cond),
    .reg_o(rg), .abs_addr_o(abs_addr), .abs_mode_o(abs_mode),
    .invert_o(inv), .cnt_o(cnt), .states_o(states));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic c, input string s);
    check_count++;
    if (c !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, s);
    end
  endtask

  // leaves the bench just after the edge where the decoder answers
  task automatic send(input logic [31:0] w, input eot_acc_e f,
                      input eot_acc_e d, input logic [3:0] mm);
    fa = f; da = d; m = mm; word = w; go = 1'b1;
    @(posedge clk) #1 go = 1'b0;
    @(posedge clk) #1;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #(3000 * 50);
    err_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk(states === 16'h0 && op === OP_NONE && done === 1'b0, "reset");
    foreach (rows[i]) begin
      send(rows[i].w, rows[i].fa, rows[i].da, rows[i].m);
      chk(done === 1'b1 && op === rows[i].op && ud === rows[i].ud,
          "op");
      chk(states === rows[i].st, "states");
    end
    for (int a = 0; a < 7; a++) begin
      send(32'h7A100000, eot_acc_e'(a), MEM, 4'h2);
      chk(states === 16'(fexp[a]) && size === SZ_LONG, "fetch cost");
      send(32'h7C506300, MEM, eot_acc_e'(a), 4'h2);
      chk(states === 16'(dexp[a]) && rg === 4'h5, "byte cost");
    end
    for (int n = 0; n < 7; n++) begin
      send({8'h79, 4'(n), 20'h0}, MEM, MEM, 4'h0);
      chk(op === eot_op_e'(5'(OP_MOV_IMM) + 5'(n)), "imm op");
      chk(size === SZ_WORD && states === 16'h4, "imm word");
    end
    for (int n = 0; n < 16; n++) begin
      send({8'h58, 4'(n), 20'h0}, MEM, MEM, 4'h0);
      chk(op === OP_BRANCH && cond === 4'(n), "branch cond");
    end
    send(32'h7EA56300, MEM, MEM, 4'h0);
    chk(abs_mode === 1'b1 && abs_addr === 8'hA5, "abs addr");
    chk(op === OP_BIT_TEST && states === 16'h6, "abs op");
    send(32'h7C007580, MEM, MEM, 4'h0);
    chk(op === OP_BIT_XOR && inv === 1'b1 && states === 16'h6, "inv");
    @(posedge clk) #1;
    en = 1'b0;
    send(32'h79000000, MEM, MEM, 4'h0);
    chk(done === 1'b0 && op === OP_BIT_XOR, "frozen");
    en = 1'b1;
    send(32'h7A300000, ACC_EXT8_3ST, MEM, 4'h3);
    chk(states === 16'h24 && op === OP_SUB_IMM, "wait states");
    rst = 1'b1;
    #1 chk(states === 16'h0 && op === OP_NONE && ud === 1'b0, "mid reset");
    @(posedge clk) #1 rst = 1'b0;
    @(posedge clk) #1;
    results();
  end
endmodule
